// ---- hdl/ica_top.v ----
// Function
// - First byte: control code, block bits, direction
// - Direction bit one reads, zero writes
// - Acknowledge a matching control byte
// - Pointer is block bits above word address
// - Byte write: acknowledge all three bytes
// - Commit data byte at its acknowledge
// - Repeated start keeps the loaded pointer
// - Read control: acknowledge, shift out byte
// - Read, write and write-all lock options
// - Lock set at reset; identity unchanged
`include "ica_consts.vh"
`default_nettype none

module ica_top #(
  parameter ADDR_W     = 11,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4,
  // Arbitrary identification value.
  parameter [31:0] IDENT_CODE = 32'h5a3c_0001
) (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   ce_in,
  input  wire                   psel_in,
  input  wire                   penable_in,
  input  wire                   pwrite_in,
  input  wire [`ICA_APB_AW-1:0] paddr_in,
  input  wire [31:0]            pwdata_in,
  output wire [31:0]            prdata_out,
  output wire                   pready_out,
  output wire                   pslverr_out,
  input  wire                   scl_in,
  input  wire                   sda_in,
  output wire                   sda_out,
  output wire                   sda_oe_out,
  output wire [ADDR_W-1:0]      mem_rd_addr_out,
  input  wire [7:0]             mem_rd_data_in,
  output wire                   mem_wr_valid_out,
  output wire [ADDR_W-1:0]      mem_wr_addr_out,
  output wire [7:0]             mem_wr_data_out,
  input  wire                   mem_wr_ready_in
);

  // ****************************************************************
  // Serial states
  // ****************************************************************
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_CTRL = 8'h02;
  localparam [7:0] S_WADR = 8'h04;
  localparam [7:0] S_WDAT = 8'h08;
  localparam [7:0] S_ACK  = 8'h10;
  localparam [7:0] S_TX   = 8'h20;
  localparam [7:0] S_MACK = 8'h40;
  localparam [7:0] S_IGN  = 8'h80;

  localparam FW = ADDR_W + 8;

  reg              scl_s1_q;
  reg              scl_s2_q;
  reg              scl_s3_q;
  reg              sda_s1_q;
  reg              sda_s2_q;
  reg              sda_s3_q;
  reg [7:0]        st_q;
  reg [7:0]        next_q;
  reg [3:0]        cnt_q;
  reg [7:0]        sh_q;
  reg              oe_q;
  reg [2:0]        blk_q;
  reg [ADDR_W-1:0] ptr_q;
  reg              mack_q;
  reg              push_q;
  reg [FW-1:0]     push_data_q;
  reg [3:0]        code_q;
  reg [2:0]        lock_q;
  reg [31:0]       prdata_q;

  wire             scl_rise;
  wire             scl_fall;
  wire             start_det;
  wire             stop_det;
  wire             byte_done;
  wire             rd_blocked;
  wire             wr_blocked;
  wire [7:0]       load_byte;
  wire             fifo_in_ready;
  wire [FW-1:0]    fifo_out_data;
  wire [FIFO_AW:0] fifo_count;
  wire             fifo_empty;
  wire             apb_setup;
  wire             apb_write;
  wire             addr_hit;
  wire [31:0]      status_word;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function prot_hit;
    input [ADDR_W-1:0] a;
    begin
      prot_hit = (a <= `ICA_PROT_LAST);
    end
  endfunction

  function mapped;
    input [`ICA_APB_AW-1:0] a;
    begin
      mapped = (a == `ICA_OFS_CTRL) | (a == `ICA_OFS_STATUS) |
               (a == `ICA_OFS_IDENT);
    end
  endfunction

  // ****************************************************************
  // Bus conditions
  // ****************************************************************
  // Only the second and third stages feed edge detection, so a
  // metastable first stage never reaches the decode.
  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign byte_done = scl_fall & (cnt_q == `ICA_BITS_PER_BYTE);

  // Locked reads return a released line rather than a refusal.
  assign rd_blocked = lock_q[`ICA_LOCK_RD] & prot_hit(ptr_q);
  assign wr_blocked = lock_q[`ICA_LOCK_ALL] |
                      (lock_q[`ICA_LOCK_WR] & prot_hit(ptr_q));
  assign load_byte  = rd_blocked ? `ICA_IDLE_BYTE : mem_rd_data_in;

  // The pin only ever pulls low; the line level is resolved outside.
  assign sda_out         = 1'b0;
  assign sda_oe_out      = oe_q;
  assign mem_rd_addr_out = ptr_q;

  // ****************************************************************
  // Serial engine
  // ****************************************************************
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      scl_s1_q    <= 1'b1;
      scl_s2_q    <= 1'b1;
      scl_s3_q    <= 1'b1;
      sda_s1_q    <= 1'b1;
      sda_s2_q    <= 1'b1;
      sda_s3_q    <= 1'b1;
      st_q        <= S_IDLE;
      next_q      <= S_IDLE;
      cnt_q       <= 4'h0;
      sh_q        <= 8'h00;
      oe_q        <= 1'b0;
      blk_q       <= 3'h0;
      ptr_q       <= {ADDR_W{1'b0}};
      mack_q      <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= {FW{1'b0}};
    end
    else if (ce_in)
    begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      push_q   <= 1'b0;
      if (start_det)
      begin
        // A repeated start drops any write in progress but leaves
        // the pointer where the word address put it.
        st_q  <= S_CTRL;
        cnt_q <= 4'h0;
        oe_q  <= 1'b0;
      end
      else if (stop_det)
      begin
        st_q <= S_IDLE;
        oe_q <= 1'b0;
      end
      else
      begin
        case (st_q)
          S_CTRL, S_WADR, S_WDAT:
          begin
            if (scl_rise)
            begin
              sh_q  <= {sh_q[6:0], sda_s2_q};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (byte_done)
            begin
              cnt_q <= 4'h0;
              if (st_q == S_CTRL)
              begin
                if (sh_q[`ICA_CC_MSB:`ICA_CC_LSB] != code_q)
                  st_q <= S_IGN;
                else
                begin
                  blk_q  <= sh_q[`ICA_BLK_MSB:`ICA_BLK_LSB];
                  oe_q   <= 1'b1;
                  st_q   <= S_ACK;
                  // Without a word address a read starts at the
                  // present pointer.
                  next_q <= sh_q[`ICA_RW_BIT] ? S_TX : S_WADR;
                end
              end
              else if (st_q == S_WADR)
              begin
                ptr_q  <= {blk_q, sh_q};
                oe_q   <= 1'b1;
                st_q   <= S_ACK;
                next_q <= S_WDAT;
              end
              else if (wr_blocked | ~fifo_in_ready)
                st_q <= S_IGN;
              else
              begin
                push_q      <= 1'b1;
                push_data_q <= {ptr_q, sh_q};
                ptr_q       <= ptr_q + 1'b1;
                oe_q        <= 1'b1;
                st_q        <= S_ACK;
                next_q      <= S_WDAT;
              end
            end
          end
          S_ACK:
          begin
            if (scl_fall)
            begin
              cnt_q <= 4'h0;
              st_q  <= next_q;
              if (next_q == S_TX)
              begin
                sh_q  <= load_byte;
                oe_q  <= ~load_byte[7];
                ptr_q <= ptr_q + 1'b1;
              end
              else
                oe_q <= 1'b0;
            end
          end
          S_TX:
          begin
            if (scl_rise)
              cnt_q <= cnt_q + 4'h1;
            else if (byte_done)
            begin
              oe_q  <= 1'b0;
              cnt_q <= 4'h0;
              st_q  <= S_MACK;
            end
            else if (scl_fall)
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
          S_MACK:
          begin
            if (scl_rise)
              mack_q <= ~sda_s2_q;
            else if (scl_fall)
            begin
              if (mack_q)
              begin
                sh_q  <= load_byte;
                oe_q  <= ~load_byte[7];
                ptr_q <= ptr_q + 1'b1;
                st_q  <= S_TX;
              end
              else
                st_q <= S_IGN;
            end
          end
          S_IDLE, S_IGN:
            oe_q <= 1'b0;
          default:
          begin
            st_q <= S_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Write buffer toward the configuration memory
  // ****************************************************************
  // A full buffer refuses the data byte with no acknowledge, so the
  // master learns of back-pressure instead of losing data.
  ica_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .in_valid_in   (push_q),
    .in_data_in    (push_data_q),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (mem_wr_valid_out),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (mem_wr_ready_in),
    .count_out     (fifo_count)
  );

  assign mem_wr_addr_out = fifo_out_data[FW-1:8];
  assign mem_wr_data_out = fifo_out_data[7:0];
  assign fifo_empty      = ~mem_wr_valid_out;

  // ****************************************************************
  // APB register slave
  // ****************************************************************
  assign apb_setup   = psel_in & ~penable_in;
  assign apb_write   = psel_in & penable_in & pwrite_in;
  assign addr_hit    = mapped(paddr_in);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_hit;
  assign prdata_out  = prdata_q;

  assign status_word = {5'h00,
                        ptr_q,
                        3'h0,
                        fifo_count,
                        5'h00,
                        fifo_empty,
                        ~fifo_in_ready,
                        ~st_q[0]};

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      code_q   <= `ICA_CODE_RST;
      // Parts come up locked against serial reads of the range.
      lock_q   <= `ICA_LOCK_RST;
      prdata_q <= `ICA_ZERO32;
    end
    else if (ce_in)
    begin
      if (apb_write & (paddr_in == `ICA_OFS_CTRL))
      begin
        code_q <= pwdata_in[`ICA_CODE_MSB:`ICA_CODE_LSB];
        // Lock bits only accumulate; clearing needs a reset, so
        // software cannot reopen a protected range.
        lock_q <= lock_q |
                  pwdata_in[`ICA_LOCK_MSB:`ICA_LOCK_LSB];
      end
      if (apb_setup)
      begin
        if (paddr_in == `ICA_OFS_CTRL)
          prdata_q <= {25'h0000000, lock_q, code_q};
        else if (paddr_in == `ICA_OFS_STATUS)
          prdata_q <= status_word;
        else if (paddr_in == `ICA_OFS_IDENT)
          prdata_q <= IDENT_CODE;
        else
          prdata_q <= `ICA_ZERO32;
      end
    end
  end

endmodule

`default_nettype wire

// ---- hdl/ica_consts.vh ----
`ifndef ICA_CONSTS_VH
`define ICA_CONSTS_VH

// ****************************************************************
// Register map and field layout
// ****************************************************************
`define ICA_APB_AW        12
`define ICA_OFS_CTRL      12'h000
`define ICA_OFS_STATUS    12'h004
`define ICA_OFS_IDENT     12'h008
`define ICA_CODE_LSB      0
`define ICA_CODE_MSB      3
`define ICA_LOCK_LSB      4
`define ICA_LOCK_MSB      6
`define ICA_LOCK_RD       0
`define ICA_LOCK_WR       1
`define ICA_LOCK_ALL      2
`define ICA_ST_BUSY       0
`define ICA_ST_FULL       1
`define ICA_ST_EMPTY      2
`define ICA_ST_CNT_LSB    8
`define ICA_ST_CNT_MSB    12
`define ICA_ST_PTR_LSB    16
`define ICA_ST_PTR_MSB    26

// ****************************************************************
// Control byte fields
// ****************************************************************
`define ICA_CC_MSB        7
`define ICA_CC_LSB        4
`define ICA_BLK_MSB       3
`define ICA_BLK_LSB       1
`define ICA_RW_BIT        0

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define ICA_CODE_RST      4'h1
`define ICA_LOCK_RST      3'h1
`define ICA_PROT_LAST     11'h0bf
`define ICA_BITS_PER_BYTE 4'h8
`define ICA_IDLE_BYTE     8'hff
`define ICA_ZERO32        32'h0000_0000

`endif

// ---- hdl/ica_fifo.v ----
`default_nettype none

// ****************************************************************
// Write buffer between the serial side and the memory port
// ****************************************************************
module ica_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             ce_in,
  input  wire             in_valid_in,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             in_ready_out,
  output wire             out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input  wire             out_ready_in,
  output wire [AW:0]      count_out
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [WIDTH-1:0] out_data_q;
  reg [AW-1:0]    wptr_q;
  reg [AW-1:0]    rptr_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  localparam [AW:0] FULL_CNT = DEPTH[AW:0];
  localparam [AW:0] ONE_CNT  = {{AW{1'b0}}, 1'b1};

  assign in_ready_out  = (cnt_q != FULL_CNT);
  assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign out_data_out  = out_data_q;
  assign count_out     = cnt_q;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      cnt_q  <= {(AW+1){1'b0}};
      out_data_q <= {WIDTH{1'b0}};
    end
    else if (ce_in)
    begin
      if (push)
      begin
        mem_q[wptr_q] <= in_data_in;
        wptr_q        <= wptr_q + 1'b1;
      end
      if (pop)
        rptr_q <= rptr_q + 1'b1;
      // The head word sits in its own register so the memory port sees
      // flop outputs; a word entering an empty buffer, or replacing the
      // only word, bypasses the array.
      if (push & (~out_valid_out | (pop & (cnt_q == ONE_CNT))))
        out_data_q <= in_data_in;
      else if (pop)
        out_data_q <= mem_q[rptr_q + 1'b1];
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- test/ica_props.sv ----
`default_nettype none
module ica_props #(
  parameter ADDR_W = 11
) (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic [11:0]       paddr_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              scl_in,
  input wire logic              sda_oe_out,
  input wire logic              mem_wr_valid_out,
  input wire logic [ADDR_W-1:0] mem_wr_addr_out,
  input wire logic [7:0]        mem_wr_data_out,
  input wire logic              mem_wr_ready_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Port checks
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic acc = psel_in && penable_in;
  wire logic map = paddr_in == 12'h000 || paddr_in == 12'h004
                   || paddr_in == 12'h008;
  AST_READY: assert property (acc |-> pready_out)
    else $error("access without ready");
  AST_UNMAPPED: assert property (acc && !map |-> pslverr_out)
    else $error("unmapped access without error");
  AST_MAPPED: assert property (acc && map |-> !pslverr_out)
    else $error("mapped access flagged");
  AST_RDATA: assert property (!(psel_in && !penable_in) |=>
    $stable(prdata_out)) else $error("read data moved");
  // The device may only start pulling the line while the clock is low.
  AST_ACK_LOW: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("drive began with clock high");
  AST_HOLD: assert property (mem_wr_valid_out && !mem_wr_ready_in
    |=> mem_wr_valid_out && $stable(mem_wr_addr_out)
    && $stable(mem_wr_data_out)) else $error("write port dropped");
  AST_PUSH: assert property ($rose(mem_wr_valid_out)
    |-> sda_oe_out && !scl_in) else $error("write without ack");
  AST_DROP: assert property ($fell(mem_wr_valid_out)
    |-> $past(mem_wr_ready_in)) else $error("write lost");
endmodule
`default_nettype wire

// ---- test/ica_i2c_master.sv ----
`default_nettype none
module ica_i2c_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Serial bus master
  // ****
  // Clock idles high between frames; each bit holds it high for 8 clocks and low for 16.
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic step;
    repeat (8) @(posedge clk_in);
  endtask
  // Data falls while clock is high, also for a repeated start.
  task automatic start;
    sda_oe_out <= 1'b0;
    step();
    scl_out <= 1'b1;
    step();
    sda_oe_out <= 1'b1;
    step();
    scl_out <= 1'b0;
    step();
  endtask
  task automatic stop;
    sda_oe_out <= 1'b1;
    step();
    scl_out <= 1'b1;
    step();
    sda_oe_out <= 1'b0;
    step();
  endtask
  task automatic xfer(input logic b, output logic r);
    sda_oe_out <= ~b;
    step();
    scl_out <= 1'b1;
    step();
    r = sda_in;
    scl_out <= 1'b0;
    step();
  endtask
  // Sent MSB first; the ninth bit is ours, released for a write.
  task automatic byte_io(input logic [7:0] d, input logic last,
                         output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) xfer(d[i], r[i]);
    xfer(last, a);
    ack = ~a;
  endtask
endmodule
`default_nettype wire

// ---- test/test_ica_top.sv ----
`default_nettype none
module test_ica_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Arbitrary identification value.
  localparam logic [31:0] ID = 32'h00c0_ffee;
  logic        clk_in;
  logic        rst_in = 1'b1;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic        wr_rdy = 1'b1;
  logic [11:0] paddr  = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, scl, m_oe, sda_o, sda_oe, wvalid;
  logic [10:0] raddr, waddr;
  logic [7:0]  rdata, wdata;
  logic [7:0]  mem [0:2047];
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  wire logic   sda = ~m_oe & ~(sda_oe & ~sda_o);
  assign rdata = mem[raddr];
  ica_top #(.IDENT_CODE(ID)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(1'b1), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .mem_rd_addr_out(raddr), .mem_rd_data_in(rdata),
    .mem_wr_valid_out(wvalid), .mem_wr_addr_out(waddr),
    .mem_wr_data_out(wdata), .mem_wr_ready_in(wr_rdy));
  ica_i2c_master m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(m_oe));
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    if (wvalid && wr_rdy)
      mem[waddr] <= wdata;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      results();
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic i2c_wr(input logic [7:0] c, a, d, output logic [2:0] k);
    logic [7:0] r;
    m.start();
    m.byte_io(c, 1'b1, r, k[2]);
    m.byte_io(a, 1'b1, r, k[1]);
    m.byte_io(d, 1'b1, r, k[0]);
    m.stop();
  endtask
  task automatic i2c_rd(input logic [7:0] c, a, input logic cur,
                        output logic [7:0] q, output logic [2:0] k);
    logic [7:0] r;
    k = 3'b000;
    if (!cur)
    begin
      m.start();
      m.byte_io(c, 1'b1, r, k[2]);
      m.byte_io(a, 1'b1, r, k[1]);
    end
    m.start();
    m.byte_io(c | 8'h01, 1'b1, r, k[0]);
    m.byte_io(8'hff, 1'b1, q, r[0]);
    m.stop();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h11);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk(r, ID);
    apb(1'b1, 12'h000, 32'h0a, r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h1a);
    apb(1'b0, 12'h00c, 32'h0, r, e);
    chk(e, 1'b1);
  endtask
  task automatic t_rw;
    logic [7:0] q;
    logic [2:0] k;
    i2c_wr(8'haa, 8'h3c, 8'ha5, k);
    chk(k, 3'b111);
    chk(mem[11'h53c], 8'ha5);
    i2c_rd(8'haa, 8'h3c, 1'b0, q, k);
    chk({k, q}, 11'h7a5);
    i2c_rd(8'haa, 8'h00, 1'b1, q, k);
    chk({k[0], q}, 9'h177);
    m.start();
    m.byte_io(8'haa, 1'b1, q, k[2]);
    m.byte_io(8'h3b, 1'b1, q, k[1]);
    m.start();
    m.byte_io(8'hab, 1'b1, q, k[0]);
    m.byte_io(8'hff, 1'b0, q, k[0]);
    chk(q, 8'h77);
    m.byte_io(8'hff, 1'b1, q, k[0]);
    chk(q, 8'ha5);
    m.stop();
    i2c_wr(8'h12, 8'h00, 8'h00, k);
    chk(k, 3'b000);
    chk(mem[11'h100], 8'h77);
  endtask
  task automatic t_fifo;
    logic [7:0] r;
    logic [31:0] s;
    logic k, e;
    wr_rdy <= 1'b0;
    m.start();
    m.byte_io(8'ha8, 1'b1, r, k);
    m.byte_io(8'h00, 1'b1, r, k);
    for (int i = 0; i < 17; i++)
    begin
      m.byte_io(8'h40 + i[7:0], 1'b1, r, k);
      chk(k, i < 16);
    end
    m.stop();
    apb(1'b0, 12'h004, 32'h0, s, e);
    chk({s[12:8], s[1]}, 6'h21);
    wr_rdy <= 1'b1;
    for (int n = 0; n < 100 && wvalid !== 1'b0; n++) @(posedge clk_in);
    for (int i = 0; i < 16; i++) chk(mem[11'h400 + i], 8'h40 + i);
    apb(1'b0, 12'h004, 32'h0, s, e);
    chk(s[2], 1'b1);
  endtask
  task automatic t_lock;
    logic [7:0] q;
    logic [2:0] k;
    logic [31:0] s;
    logic e;
    i2c_rd(8'ha0, 8'h10, 1'b0, q, k);
    chk(q, 8'hff);
    apb(1'b1, 12'h000, 32'h2a, s, e);
    i2c_wr(8'ha0, 8'h10, 8'h55, k);
    chk(k, 3'b110);
    i2c_wr(8'hac, 8'h00, 8'h66, k);
    chk(k, 3'b111);
    apb(1'b1, 12'h000, 32'h4a, s, e);
    i2c_wr(8'hac, 8'h00, 8'h99, k);
    chk(k, 3'b110);
    chk(mem[11'h010], 8'h77);
    chk(mem[11'h600], 8'h66);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'h77;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_rw();
    t_fifo();
    t_lock();
    results();
  end
endmodule
bind ica_top ica_props #(.ADDR_W(ADDR_W)) chk_i (.clk_in(clk_in),
  .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
  .mem_wr_valid_out(mem_wr_valid_out), .mem_wr_addr_out(mem_wr_addr_out),
  .mem_wr_data_out(mem_wr_data_out), .mem_wr_ready_in(mem_wr_ready_in));
`default_nettype wire
